// ==== core/sysconf.sv ====
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// What this block does
// - Block clock always runs from internal RC; registers reachable without setup.
// - Main selector offers RC, external input, watchdog osc, PLL, 32 kHz.
// - System clock is the selected main clock divided down.
// - Divider value zero stops the system clock completely.
// - Core clock always on; memory/peripheral clocks gated by two registers.
// - Mux starts a switch only while old and new sources both run.
// - PLL input is selectable among several clocks.
// - PLL output is selectable for the clock output pin.
// - Word-aligned registers decoded in the main address group only.
// - Bus clock gate set/clear aliases change only selected bits.
// - Peripheral reset set/clear aliases change only selected bits.
// - Power-on reset captures port 0 and port 1 levels.
// - Warm reset captures port 0 and port 1 levels separately.
// - Two select registers together pick the main source.
// - Two select registers together pick the clock pin source.
// - System divider resets to one so system clock runs.
// - Reset cause status register is readable and writable.
// - Reset cause register value follows the latest reset source.
// - Warm captures sample on every reset, POR included; POR captures only on POR.
module sysconf
    import sysconf_pkg::*;
(
    input  wire logic                        I_CLOCK,
    input  wire logic                        I_RST_B,
    input  wire logic [31:0]                 I_ADDR,
    input  wire logic [31:0]                 I_WDATA,
    input  wire logic                        I_WR,
    input  wire logic                        I_RD,
    input  wire logic [4:0]                  I_SRC_RUN,
    input  wire logic [sysconf_pkg::CAUSE_W-1:0] I_RST_CAUSE,
    input  wire logic [31:0]                 I_PORT0,
    input  wire logic [31:0]                 I_PORT1,
    output logic [31:0]                      O_RDATA,
    output sysconf_pkg::src_t                O_MAIN_SRC,
    output logic                             O_SWITCH_BUSY,
    output logic                             O_SYS_TICK,
    output sysconf_pkg::pin_src_t            O_PIN_SRC,
    output logic [1:0]                       O_PLL_SRC,
    output sysconf_pkg::periph_ctl_t         O_PERIPH
);
    import sysconf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Decode
    function automatic logic grp_main(input logic [31:0] a);
        grp_main = (a[31:12] == MAIN_BASE) && (a[1:0] == 2'h0);
    endfunction : grp_main

    function automatic logic [3:0] plain_idx(input logic [11:0] o);
        unique case (o)
            OFS_MATPRIO:  plain_idx = 4'h8;
            OFS_TICKCAL:  plain_idx = 4'h9;
            OFS_NONMASKABLE_SOURCE_SELECT:   plain_idx = 4'hA;
            OFS_ASYNCCTL: plain_idx = 4'hB;
            OFS_ADCSEL:   plain_idx = 4'hC;
            OFS_TICKDIV:  plain_idx = 4'hD;
            OFS_ADCDIV:   plain_idx = 4'hE;
            OFS_PLLSEL:   plain_idx = 4'hF;
            default:      plain_idx = 4'h0;
        endcase
    endfunction : plain_idx

    logic [11:0] ofs;
    logic        wr_m;
    logic        rd_m;
    assign ofs  = I_ADDR[11:0];
    // Other groups hold only registers outside this block: read zero
    assign wr_m = I_WR && grp_main(I_ADDR);
    assign rd_m = I_RD && grp_main(I_ADDR);

    function automatic logic hit(input logic [11:0] o);
        hit = wr_m && (ofs == o);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // Plain storage registers
    logic [31:0] plain_ff [NPLAIN];
    logic [3:0]  pidx;
    assign pidx = plain_idx(ofs);

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            for (int i = 0; i < NPLAIN; i++) begin
                plain_ff[i] <= 32'h0000_0000;
            end
            plain_ff[3] <= RST_ASYNCCTL;
        end else if (wr_m && pidx[3]) begin
            plain_ff[pidx[2:0]] <= I_WDATA;
        end
    end

    // PLL input choice, taken from the low bits
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            O_PLL_SRC <= 2'h0;
        end else begin
            O_PLL_SRC <= plain_ff[7][1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Gates and peripheral resets
    function automatic logic [31:0] setclr(
        input logic [31:0] cur,
        input logic        wr_plain,
        input logic        wr_set,
        input logic        wr_clr,
        input logic [31:0] d
    );
        setclr = cur;
        if (wr_plain) begin
            setclr = d;
        end
        if (wr_set) begin
            setclr = cur | d;
        end
        if (wr_clr) begin
            setclr = cur & ~d;
        end
    endfunction : setclr

    // Core clock is not in these masks; it never stops
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            O_PERIPH.gate0 <= RST_GATE0;
            O_PERIPH.gate1 <= 32'h0000_0000;
        end else begin
            O_PERIPH.gate0 <= setclr(O_PERIPH.gate0, hit(OFS_GATE0),
                hit(OFS_GATESET0), hit(OFS_GATECLR0), I_WDATA);
            O_PERIPH.gate1 <= setclr(O_PERIPH.gate1, hit(OFS_GATE1),
                hit(OFS_GATESET1), hit(OFS_GATECLR1), I_WDATA);
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            O_PERIPH.prst0 <= 32'h0000_0000;
            O_PERIPH.prst1 <= 32'h0000_0000;
        end else begin
            O_PERIPH.prst0 <= setclr(O_PERIPH.prst0, hit(OFS_PRST0),
                hit(OFS_PRSTSET0), hit(OFS_PRSTCLR0), I_WDATA);
            O_PERIPH.prst1 <= setclr(O_PERIPH.prst1, hit(OFS_PRST1),
                hit(OFS_PRSTSET1), hit(OFS_PRSTCLR1), I_WDATA);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reset cause and port capture
    logic [CAUSE_W-1:0] cause_ff;
    logic               cap_done_ff;
    logic [31:0]        por0_ff;
    logic [31:0]        por1_ff;
    logic [31:0]        res0_ff;
    logic [31:0]        res1_ff;
    logic               first_cyc;
    logic               is_por;
    assign first_cyc = I_RST_B && !cap_done_ff;
    assign is_por    = I_RST_CAUSE[CAUSE_POR];

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            cap_done_ff <= 1'b0;
        end else begin
            cap_done_ff <= 1'b1;
        end
    end

    // Caught just after release; write-one clears, capture wins
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            cause_ff <= '0;
        end else if (first_cyc) begin
            cause_ff <= I_RST_CAUSE;
        end else if (hit(OFS_RSTCAUSE)) begin
            cause_ff <= cause_ff & ~I_WDATA[CAUSE_W-1:0];
        end
    end

    // No reset: POR values must survive warm resets
    always_ff @(posedge I_CLOCK) begin
        if (first_cyc && is_por) begin
            por0_ff <= I_PORT0;
            por1_ff <= I_PORT1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (first_cyc) begin
            res0_ff <= I_PORT0;
            res1_ff <= I_PORT1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Source run status, three-stage sync
    logic [4:0] run1_ff;
    logic [4:0] run2_ff;
    logic [4:0] run3_ff;
    logic [4:0] run_ok_ff;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            run1_ff   <= 5'h01;
            run2_ff   <= 5'h01;
            run3_ff   <= 5'h01;
            run_ok_ff <= 5'h01;
        end else begin
            run1_ff <= I_SRC_RUN;
            run2_ff <= run1_ff;
            run3_ff <= run2_ff;
            for (int i = 0; i < 5; i++) begin
                if (run2_ff[i] == run3_ff[i]) begin
                    run_ok_ff[i] <= run2_ff[i];
                end
            end
            // Block clock source is always alive
            run_ok_ff[0] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main and pin select registers
    logic [SEL_A_W-1:0] msel_a_ff;
    logic [SEL_B_W-1:0] msel_b_ff;
    logic [PIN_A_W-1:0] psel_a_ff;
    logic [SEL_B_W-1:0] psel_b_ff;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            msel_a_ff <= '0;
            msel_b_ff <= '0;
            psel_a_ff <= '0;
            psel_b_ff <= '0;
        end else begin
            if (hit(OFS_MAINSELA)) begin
                msel_a_ff <= I_WDATA[SEL_A_W-1:0];
            end
            if (hit(OFS_MAINSELB)) begin
                msel_b_ff <= I_WDATA[SEL_B_W-1:0];
            end
            if (hit(OFS_PINSELA)) begin
                psel_a_ff <= I_WDATA[PIN_A_W-1:0];
            end
            if (hit(OFS_PINSELB)) begin
                psel_b_ff <= I_WDATA[SEL_B_W-1:0];
            end
        end
    end

    function automatic src_t main_of(
        input logic [SEL_A_W-1:0] a,
        input logic [SEL_B_W-1:0] b
    );
        unique case (b)
            2'h2:    main_of = SRC_PLL;
            2'h3:    main_of = SRC_RTC;
            default: main_of = src_t'({1'b0, a});
        endcase
    endfunction : main_of

    src_t req_src;
    assign req_src = main_of(msel_a_ff, msel_b_ff);

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            O_PIN_SRC <= PIN_MAIN;
        end else begin
            unique case (psel_b_ff)
                2'h1:    O_PIN_SRC <= PIN_PLL;
                2'h2:    O_PIN_SRC <= PIN_RTC;
                2'h3:    O_PIN_SRC <= PIN_OFF;
                default: O_PIN_SRC <= (psel_a_ff > 3'h3) ? PIN_OFF
                                      : pin_src_t'(psel_a_ff);
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Glitch-free handover
    sw_state_t   sw_ff;
    src_t        tgt_ff;
    logic [2:0]  hcnt_ff;
    logic        both_run;
    localparam logic [2:0] HC_LAST = 3'(HANDOVER_CYC - 1);
    assign both_run = run_ok_ff[O_MAIN_SRC] && run_ok_ff[req_src];

    // A stopped source keeps the switch in SW_IDLE; run status is not rechecked once it starts
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            sw_ff         <= SW_IDLE;
            tgt_ff        <= SRC_IRC;
            hcnt_ff       <= 3'h0;
            O_MAIN_SRC    <= SRC_IRC;
            O_SWITCH_BUSY <= 1'b0;
        end else begin
            unique case (sw_ff)
                SW_IDLE: begin
                    if (req_src != O_MAIN_SRC && both_run) begin
                        sw_ff         <= SW_DROP;
                        tgt_ff        <= req_src;
                        hcnt_ff       <= 3'h0;
                        O_SWITCH_BUSY <= 1'b1;
                    end
                end
                SW_DROP: begin
                    hcnt_ff <= hcnt_ff + 3'h1;
                    if (hcnt_ff == HC_LAST) begin
                        sw_ff   <= SW_TAKE;
                        hcnt_ff <= 3'h0;
                    end
                end
                SW_TAKE: begin
                    hcnt_ff <= hcnt_ff + 3'h1;
                    if (hcnt_ff == HC_LAST) begin
                        sw_ff         <= SW_IDLE;
                        O_MAIN_SRC    <= tgt_ff;
                        O_SWITCH_BUSY <= 1'b0;
                    end
                end
                default: begin
                    sw_ff <= SW_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // System clock divider, as a tick
    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] cur_ff;
    logic [DIV_W-1:0] cnt_ff;
    logic             end_per;
    assign end_per = (cur_ff == '0) || (cnt_ff == cur_ff - 8'h01);

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            div_ff <= RST_SYSDIV;
        end else if (hit(OFS_SYSDIV)) begin
            div_ff <= I_WDATA[DIV_W-1:0];
        end
    end

    // New value waits for the period end: no runt
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            cur_ff     <= RST_SYSDIV;
            cnt_ff     <= '0;
            O_SYS_TICK <= 1'b0;
        end else begin
            O_SYS_TICK <= (cur_ff != '0) && end_per;
            if (end_per) begin
                cnt_ff <= '0;
                cur_ff <= div_ff;
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            O_RDATA <= 32'h0000_0000;
        end else if (!rd_m) begin
            O_RDATA <= 32'h0000_0000;
        end else if (pidx[3]) begin
            O_RDATA <= plain_ff[pidx[2:0]];
        end else begin
            unique case (ofs)
                OFS_RSTCAUSE: O_RDATA <= 32'(cause_ff);
                OFS_PRST0:    O_RDATA <= O_PERIPH.prst0;
                OFS_PRST1:    O_RDATA <= O_PERIPH.prst1;
                OFS_PORCAP0:  O_RDATA <= por0_ff;
                OFS_PORCAP1:  O_RDATA <= por1_ff;
                OFS_RESCAP0:  O_RDATA <= res0_ff;
                OFS_RESCAP1:  O_RDATA <= res1_ff;
                OFS_MAINSELA: O_RDATA <= 32'(msel_a_ff);
                OFS_MAINSELB: O_RDATA <= 32'(msel_b_ff);
                OFS_PINSELA:  O_RDATA <= 32'(psel_a_ff);
                OFS_PINSELB:  O_RDATA <= 32'(psel_b_ff);
                OFS_GATE0:    O_RDATA <= O_PERIPH.gate0;
                OFS_GATE1:    O_RDATA <= O_PERIPH.gate1;
                OFS_SYSDIV:   O_RDATA <= 32'(div_ff);
                default:      O_RDATA <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);

    sequence set0_wr;
        hit(OFS_GATESET0) && !hit(OFS_GATE0);
    endsequence

    gate_set_a: assert property (set0_wr |=>
        O_PERIPH.gate0 == ($past(O_PERIPH.gate0) | $past(I_WDATA)))
        else $error("gate set alias wrong");

    prst_clr_a: assert property (hit(OFS_PRSTCLR1) |=>
        O_PERIPH.prst1 == ($past(O_PERIPH.prst1) & ~$past(I_WDATA)))
        else $error("reset clear alias wrong");

    div_stop_a: assert property ((cur_ff == '0) |=> !O_SYS_TICK)
        else $error("tick with divider zero");

    sequence tick_n2;
        O_SYS_TICK && cur_ff == 8'h02 && div_ff == 8'h02;
    endsequence

    div_two_a: assert property (tick_n2 |-> ##1 !O_SYS_TICK ##1 O_SYS_TICK)
        else $error("divide by two period wrong");

    sequence sw_start;
        sw_ff == SW_IDLE && O_SWITCH_BUSY == 1'b0 && req_src != O_MAIN_SRC;
    endsequence

    sw_guard_a: assert property (sw_start and !both_run |=>
        sw_ff == SW_IDLE && $stable(O_MAIN_SRC))
        else $error("switch with dead source");

    sw_time_a: assert property (sw_start and both_run |=>
        $stable(O_MAIN_SRC)[*4] ##1 O_MAIN_SRC == $past(tgt_ff))
        else $error("handover timing wrong");

    por_keep_a: assert property (first_cyc && !is_por |=>
        $stable(por0_ff) && $stable(por1_ff))
        else $error("POR capture changed on warm reset");

    rd_zero_a: assert property (I_RD && !grp_main(I_ADDR) |=>
        O_RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    cause_a: assert property (first_cyc |=> cause_ff == $past(I_RST_CAUSE))
        else $error("reset cause not captured");
endmodule : sysconf

// ==== core/sysconf_pkg.sv ====
package sysconf_pkg;
    // Documented frequencies
    localparam int IRC_HZ      = 12_000_000;
    localparam int RTC_OSC_HZ  = 32_000;
    localparam int MAX_HZ      = 100_000_000;
    localparam int PLL_MIN_HZ  = 1_200_000;
    localparam int CLK_PERIOD_NS = 100;
    // Handover: two stages in each of old and new source
    localparam int HANDOVER_NS  = 200;
    localparam int HANDOVER_CYC =
        (HANDOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Address groups
    localparam logic [19:0] MAIN_BASE  = 20'h40000;
    localparam logic [19:0] ASYNC_BASE = 20'h40080;
    localparam logic [19:0] OTHER_BASE = 20'h4002C;

    // Offsets, main group
    localparam logic [11:0] OFS_MATPRIO  = 12'h004;
    localparam logic [11:0] OFS_TICKCAL  = 12'h014;
    localparam logic [11:0] OFS_NONMASKABLE_SOURCE_SELECT   = 12'h01C;
    localparam logic [11:0] OFS_ASYNCCTL = 12'h020;
    localparam logic [11:0] OFS_RSTCAUSE = 12'h040;
    localparam logic [11:0] OFS_PRST0    = 12'h044;
    localparam logic [11:0] OFS_PRST1    = 12'h048;
    localparam logic [11:0] OFS_PRSTSET0 = 12'h04C;
    localparam logic [11:0] OFS_PRSTSET1 = 12'h050;
    localparam logic [11:0] OFS_PRSTCLR0 = 12'h054;
    localparam logic [11:0] OFS_PRSTCLR1 = 12'h058;
    localparam logic [11:0] OFS_PORCAP0  = 12'h05C;
    localparam logic [11:0] OFS_PORCAP1  = 12'h060;
    localparam logic [11:0] OFS_RESCAP0  = 12'h068;
    localparam logic [11:0] OFS_RESCAP1  = 12'h06C;
    localparam logic [11:0] OFS_MAINSELA = 12'h080;
    localparam logic [11:0] OFS_MAINSELB = 12'h084;
    localparam logic [11:0] OFS_ADCSEL   = 12'h08C;
    localparam logic [11:0] OFS_PINSELA  = 12'h094;
    localparam logic [11:0] OFS_PINSELB  = 12'h098;
    localparam logic [11:0] OFS_PLLSEL   = 12'h0A0;
    localparam logic [11:0] OFS_GATE0    = 12'h0C0;
    localparam logic [11:0] OFS_GATE1    = 12'h0C4;
    localparam logic [11:0] OFS_GATESET0 = 12'h0C8;
    localparam logic [11:0] OFS_GATESET1 = 12'h0CC;
    localparam logic [11:0] OFS_GATECLR0 = 12'h0D0;
    localparam logic [11:0] OFS_GATECLR1 = 12'h0D4;
    localparam logic [11:0] OFS_TICKDIV  = 12'h0E0;
    localparam logic [11:0] OFS_SYSDIV   = 12'h100;
    localparam logic [11:0] OFS_ADCDIV   = 12'h108;

    // Reset values
    localparam logic [31:0] RST_ASYNCCTL = 32'h0000_0001;
    localparam logic [31:0] RST_GATE0    = 32'h0000_018B;
    localparam logic [7:0]  RST_SYSDIV   = 8'h01;

    // Field layout
    localparam int SEL_A_W  = 2;
    localparam int SEL_B_W  = 2;
    localparam int PIN_A_W  = 3;
    localparam int DIV_W    = 8;
    localparam int CAUSE_W  = 4;
    localparam int CAUSE_POR = 0;
    localparam int NPLAIN   = 8;

    typedef enum logic [2:0] {
        SRC_IRC   = 3'h0,
        SRC_EXT   = 3'h1,
        SRC_WDOSC = 3'h2,
        SRC_PLL   = 3'h3,
        SRC_RTC   = 3'h4
    } src_t;

    typedef enum logic [2:0] {
        PIN_MAIN  = 3'h0,
        PIN_EXT   = 3'h1,
        PIN_WDOSC = 3'h2,
        PIN_IRC   = 3'h3,
        PIN_PLL   = 3'h4,
        PIN_RTC   = 3'h5,
        PIN_OFF   = 3'h7
    } pin_src_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_DROP = 2'b01,
        SW_TAKE = 2'b10
    } sw_state_t;

    // Peripheral-side control bundle
    typedef struct packed {
        logic [31:0] gate0;
        logic [31:0] gate1;
        logic [31:0] prst0;
        logic [31:0] prst1;
    } periph_ctl_t;
endpackage : sysconf_pkg

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import sysconf_pkg::*;
    logic                I_CLOCK, I_RST_B, I_WR, I_RD;
    logic [31:0]         I_ADDR, I_WDATA, I_PORT0, I_PORT1, O_RDATA;
    logic [4:0]          I_SRC_RUN;
    logic [CAUSE_W-1:0]  I_RST_CAUSE;
    src_t                O_MAIN_SRC;
    pin_src_t            O_PIN_SRC;
    logic                O_SWITCH_BUSY, O_SYS_TICK;
    logic [1:0]          O_PLL_SRC;
    periph_ctl_t         O_PERIPH;
    int                  fail_count, tests_run, k;
    logic [11:0]         ofs [0:20];
    logic [11:0]         b;
    logic [31:0]         e, busy_seen;

    sysconf u_sysconf (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_SRC_RUN(I_SRC_RUN),
        .I_RST_CAUSE(I_RST_CAUSE), .I_PORT0(I_PORT0), .I_PORT1(I_PORT1),
        .O_RDATA(O_RDATA), .O_MAIN_SRC(O_MAIN_SRC),
        .O_SWITCH_BUSY(O_SWITCH_BUSY), .O_SYS_TICK(O_SYS_TICK),
        .O_PIN_SRC(O_PIN_SRC), .O_PLL_SRC(O_PLL_SRC), .O_PERIPH(O_PERIPH));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        I_CLOCK = 1'b0;
        forever #50 I_CLOCK = ~I_CLOCK;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] at(input logic [11:0] o);
        return {MAIN_BASE, o};
    endfunction : at

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge I_CLOCK);
        I_WR    <= 1'b1;
        I_ADDR  <= a;
        I_WDATA <= d;
        @(posedge I_CLOCK);
        I_WR    <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the taking edge
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge I_CLOCK);
        I_RD   <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLOCK);
        I_RD   <= 1'b0;
        #1 chk(O_RDATA, exp);
    endtask : rd

    // Port levels held through the first edge after release
    task automatic rst(input logic [3:0] c, input logic [31:0] p0, p1);
        @(posedge I_CLOCK);
        I_RST_B     <= 1'b0;
        I_RST_CAUSE <= c;
        I_PORT0     <= p0;
        I_PORT1     <= p1;
        repeat (4) @(posedge I_CLOCK);
        I_RST_B <= 1'b1;
        repeat (3) @(posedge I_CLOCK);
        I_PORT0 <= ~p0;
        I_PORT1 <= ~p1;
    endtask : rst

    task automatic ticks(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge I_CLOCK);
            #1 if (O_SYS_TICK === 1'b1) cnt++;
        end
    endtask : ticks

    // Bounded wait: a stuck handover must not hang the run
    task automatic settle(input src_t exp);
        int n;
        n = 0;
        while (!(O_MAIN_SRC === exp && O_SWITCH_BUSY === 1'b0) && n < 60) begin
            @(posedge I_CLOCK);
            #1 if (O_SWITCH_BUSY === 1'b1) busy_seen = 1;
            n++;
        end
        chk(O_MAIN_SRC, exp);
    endtask : settle

    task automatic stop_test;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge I_CLOCK);
        fail_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0; tests_run = 0;
        I_RST_B = 1'b0; I_WR = 1'b0; I_RD = 1'b0; I_ADDR = '0; I_WDATA = '0;
        I_SRC_RUN = 5'h01; I_RST_CAUSE = 4'h1;
        I_PORT0 = 32'hA5A5_0F0F; I_PORT1 = 32'h1234_5678;
        rst(4'h1, 32'hA5A5_0F0F, 32'h1234_5678);
        // Reset values, write-only aliases read back zero
        ofs = '{12'h004, 12'h014, 12'h01C, 12'h020, 12'h044, 12'h048,
                12'h080, 12'h084, 12'h08C, 12'h094, 12'h098, 12'h0A0,
                12'h0C0, 12'h0C4, 12'h0E0, 12'h100, 12'h108, 12'h04C,
                12'h0D0, 12'h0C8, 12'h008};
        foreach (ofs[i]) begin
            e = (ofs[i] == OFS_ASYNCCTL || ofs[i] == OFS_SYSDIV) ? 32'h1 :
                (ofs[i] == OFS_GATE0) ? 32'h0000_018B : 32'h0;
            rd(at(ofs[i]), e);
        end
        chk(O_MAIN_SRC, SRC_IRC);
        rd(at(OFS_PORCAP0), 32'hA5A5_0F0F);
        rd(at(OFS_PORCAP1), 32'h1234_5678);
        rd(at(OFS_RSTCAUSE), 32'h1);
        // Warm reset: new warm captures, power-on ones kept
        rst(4'h2, 32'h0000_C3C3, 32'hFFFF_0001);
        rd(at(OFS_RESCAP0), 32'h0000_C3C3);
        rd(at(OFS_RESCAP1), 32'hFFFF_0001);
        rd(at(OFS_PORCAP0), 32'hA5A5_0F0F);
        rd(at(OFS_RSTCAUSE), 32'h2);
        wr(at(OFS_RSTCAUSE), 32'hF);
        rd(at(OFS_RSTCAUSE), 32'h0);
        // Set and clear aliases touch only chosen bits
        // Set alias sits 0x8 above its register, clear alias 0x10
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? OFS_GATE0 : (i == 1) ? OFS_GATE1 :
                (i == 2) ? OFS_PRST0 : OFS_PRST1;
            e = (i == 0) ? 32'h0000_018B : 32'h0;
            wr(at(b + 12'h008), 32'hF000_0030);
            rd(at(b), e | 32'hF000_0030);
            wr(at(b + 12'h010), 32'h3000_0021);
            rd(at(b), (e | 32'hF000_0030) & ~32'h3000_0021);
        end
        chk(O_PERIPH.gate0, 32'hC000_019A);
        chk(O_PERIPH.prst1, 32'hC000_0010);
        // Other groups, misaligned and reserved places are ignored
        // Only listed registers are written, never reserved places
        wr({OTHER_BASE, OFS_PRST0}, 32'hFFFF_FFFF);
        rd(at(OFS_PRST0), 32'hC000_0010);
        rd({ASYNC_BASE, 12'h028}, 32'h0);
        rd(at(OFS_SYSDIV) | 32'h2, 32'h0);
        rd(at(12'h008), 32'h0);
        rd(at(OFS_SYSDIV), 32'h1);
        // Divider: exact period, zero stops, one every cycle
        wr(at(OFS_SYSDIV), 32'h3);
        repeat (8) @(posedge I_CLOCK);
        ticks(30, k);
        chk(k, 10);
        wr(at(OFS_SYSDIV), 32'h0);
        repeat (4) @(posedge I_CLOCK);
        ticks(20, k);
        chk(k, 0);
        wr(at(OFS_SYSDIV), 32'h1);
        repeat (4) @(posedge I_CLOCK);
        ticks(20, k);
        chk(k, 20);
        wr(at(OFS_SYSDIV), 32'h2);
        repeat (4) @(posedge I_CLOCK);
        ticks(20, k);
        chk(k, 10);
        // Switch waits while the new source is stopped
        wr(at(OFS_MAINSELA), 32'h1);
        repeat (12) @(posedge I_CLOCK);
        I_SRC_RUN <= 5'h1F;
        #1 chk(O_MAIN_SRC, SRC_IRC);
        chk(O_SWITCH_BUSY, 1'b0);
        for (int i = 0; i < 5; i++) begin
            busy_seen = 0;
            wr(at(OFS_MAINSELB), (i == 2) ? 32'h2 : (i == 3) ? 32'h3 : 32'h0);
            wr(at(OFS_MAINSELA), (i == 0) ? 32'h1 : (i == 1) ? 32'h2 : 32'h0);
            settle(src_t'(i == 4 ? 0 : i + 1));
            chk(busy_seen, 1);
        end
        // Clock pin source selection and PLL input
        for (int i = 0; i < 7; i++) begin
            wr(at(OFS_PINSELB), (i < 4) ? 32'h0 : i - 3);
            wr(at(OFS_PINSELA), (i < 4) ? i : 0);
            repeat (3) @(posedge I_CLOCK);
            e = (i < 4) ? i : (i == 4) ? PIN_PLL : (i == 5) ? PIN_RTC : PIN_OFF;
            #1 chk(O_PIN_SRC, e);
        end
        for (int i = 0; i < 4; i++) begin
            wr(at(OFS_PLLSEL), i);
            repeat (3) @(posedge I_CLOCK);
            #1 chk(O_PLL_SRC, i);
        end
        stop_test();
    end
endmodule : testbench
